// *** core/vtr_pkg.sv ***
package vtr_pkg;
  // ==========================================================
  // entry layout
  // ==========================================================
  localparam int VTR_PORTS = 3;
  localparam int VTR_ENTRY_W = 18;
  localparam int VTR_VID_W = 12;
  localparam int VTR_PRI_W = 3;
  localparam int VTR_VID_LSB = 0;
  localparam int VTR_PRI_LSB = 12;
  localparam int VTR_UNTAG_BIT0 = 12;
  localparam int VTR_MEMBER_BIT0 = 13;
  localparam int VTR_PORT_STRIDE = 2;

  // ==========================================================
  // register map and reset values
  // ==========================================================
  localparam logic [15:0] VTR_READ_DATA_OFFSET = 16'h180E;
  localparam logic [15:0] VTR_CMD_STATUS_OFFSET = 16'h1810;
  localparam logic [31:0] VTR_READ_DATA_RESET = 32'h0000_0000;
  localparam logic [VTR_ENTRY_W-1:0] VTR_ENTRY_RESET = 18'h0_0000;
  localparam logic [11:0] VTR_NULL_VID = 12'h000;
  localparam logic [11:0] VTR_PVID_RESET = 12'h000;
  localparam logic [2:0] VTR_PPRI_RESET = 3'h0;

  // ==========================================================
  // timing and sizes
  // ==========================================================
  localparam int VTR_CMD_LATENCY = 2;
  localparam int VTR_DEFAULT_ENTRIES = 16;

  typedef enum logic [0:0] {VTR_IDLE, VTR_BUSY} vtr_state_type;

  function automatic logic vtr_member(
    input logic [VTR_ENTRY_W-1:0] entry,
    input int port
  );
    return entry[VTR_MEMBER_BIT0 + VTR_PORT_STRIDE * port];
  endfunction : vtr_member

  function automatic logic vtr_untag(
    input logic [VTR_ENTRY_W-1:0] entry,
    input int port
  );
    return entry[VTR_UNTAG_BIT0 + VTR_PORT_STRIDE * port];
  endfunction : vtr_untag

  function automatic logic [VTR_VID_W-1:0] vtr_vid(
    input logic [VTR_ENTRY_W-1:0] entry
  );
    return entry[VTR_VID_LSB +: VTR_VID_W];
  endfunction : vtr_vid
endpackage : vtr_pkg

// *** core/vtr_vlan_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module vtr_vlan_store
  import vtr_pkg::*;
#(
  parameter int ENTRIES = VTR_DEFAULT_ENTRIES,
  parameter int IDX_W = $clog2(ENTRIES)
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_index,
  input wire logic [VTR_ENTRY_W-1:0] wr_entry,
  input wire logic [IDX_W-1:0] rd_index,
  output logic [VTR_ENTRY_W-1:0] rd_entry,
  input wire logic [VTR_VID_W-1:0] search_vid,
  output logic search_hit,
  output logic [VTR_ENTRY_W-1:0] search_entry
);
  logic [VTR_ENTRY_W-1:0] mem_q [ENTRIES];
  logic [VTR_ENTRY_W-1:0] mem_d [ENTRIES];

  // ==========================================================
  // storage
  // ==========================================================
  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_en) begin
      mem_d[wr_index] = wr_entry;
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < ENTRIES; i++) begin
      if (sys_rst) begin
        mem_q[i] <= VTR_ENTRY_RESET; // see R9
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  assign rd_entry = mem_q[rd_index];

  // ==========================================================
  // search, lowest index wins
  // ==========================================================
  always_comb begin
    search_hit = 1'b0;
    search_entry = VTR_ENTRY_RESET;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      // a null vid marks a disabled entry, never a match
      if (vtr_vid(mem_q[i]) != VTR_NULL_VID &&
          vtr_vid(mem_q[i]) == search_vid) begin // see R10
        search_hit = 1'b1;
        search_entry = mem_q[i];
      end
    end
  end
endmodule : vtr_vlan_store
`default_nettype wire

// *** core/vtr_read_data.sv ***
// Functional notes
// R1 - 32-bit read-only result register; bits 31:18 reserved, 17:0 entry.
// R2 - port table read: default vid in 11:0, default priority in 14:12.
// R3 - untagged or null-vid frames take their port's default vid and priority.
// R4 - port defaults and the read register reset to zero.
// R5 - member bit set: accept matching frames, port joins egress domain.
// R6 - member clear: drop unless non-member admission on; leave egress domain.
// R7 - untag bit set: strip tag when sent out on hybrid egress ports; the code applies the ingress port's untag bit to every hybrid member port.
// R8 - port 1 member/untag at 15/14, port 0 at 13/12.
// R9 - vlan entry vid in bits 11:0, reset zero.
// R10 - software uses vid zero only to disable an entry.
// R11 - pending bit high while a command runs, cleared by hardware.
// R12 - read register loads only when a read command completes.
`timescale 1ns/1ps
`default_nettype none
module vtr_read_data
  import vtr_pkg::*;
#(
  parameter int ENTRIES = VTR_DEFAULT_ENTRIES,
  parameter int IDX_W = $clog2(ENTRIES)
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_rd_addr,
  output logic [31:0] reg_rd_data,
  input wire logic cmd_start,
  input wire logic cmd_read,
  input wire logic table_select_port_default,
  input wire logic [IDX_W-1:0] cmd_index,
  input wire logic [VTR_ENTRY_W-1:0] cmd_wr_data,
  output logic vlan_command_status,
  input wire logic [VTR_PORTS-1:0] admit_nonmember_config,
  input wire logic [VTR_PORTS-1:0] egress_port_type_config,
  input wire logic frm_valid,
  input wire logic [1:0] frm_port,
  input wire logic frm_tagged,
  input wire logic [VTR_VID_W-1:0] frm_vid,
  input wire logic [VTR_PRI_W-1:0] frm_pri,
  output logic cls_valid,
  output logic [VTR_VID_W-1:0] cls_vid,
  output logic [VTR_PRI_W-1:0] cls_pri,
  output logic cls_accept,
  output logic [VTR_PORTS-1:0] cls_fwd_mask,
  output logic [VTR_PORTS-1:0] cls_untag_mask
);
  localparam int CNT_W = $clog2(VTR_CMD_LATENCY + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(VTR_CMD_LATENCY - 1);

  if (ENTRIES < 4 || (1 << IDX_W) != ENTRIES) begin : g_bad_entries
    $error("ENTRIES must be a power of two of at least 4");
  end

  // ==========================================================
  // command sequencer
  // ==========================================================
  vtr_state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic rd_q, rd_d;
  logic sel_q, sel_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic [VTR_ENTRY_W-1:0] wdat_q, wdat_d;
  logic done;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    sel_d = sel_q;
    idx_d = idx_q;
    wdat_d = wdat_q;
    done = 1'b0;
    case (state_q)
      VTR_IDLE: begin
        // a start while busy is dropped, not queued
        if (cmd_start) begin
          state_d = VTR_BUSY;
          cnt_d = '0;
          rd_d = cmd_read;
          sel_d = table_select_port_default;
          idx_d = cmd_index;
          wdat_d = cmd_wr_data;
        end
      end
      VTR_BUSY: begin
        if (cnt_q == CNT_LAST) begin
          state_d = VTR_IDLE;
          done = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: state_d = VTR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= VTR_IDLE;
      cnt_q <= '0;
      rd_q <= 1'b0;
      sel_q <= 1'b0;
      idx_q <= '0;
      wdat_q <= VTR_ENTRY_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      sel_q <= sel_d;
      idx_q <= idx_d;
      wdat_q <= wdat_d;
    end
  end

  assign vlan_command_status = (state_q == VTR_BUSY); // see R11

  // ==========================================================
  // per-port default vid and priority
  // ==========================================================
  logic [VTR_VID_W-1:0] pvid_q [VTR_PORTS];
  logic [VTR_VID_W-1:0] pvid_d [VTR_PORTS];
  logic [VTR_PRI_W-1:0] ppri_q [VTR_PORTS];
  logic [VTR_PRI_W-1:0] ppri_d [VTR_PORTS];
  logic port_ok;

  assign port_ok = 32'(idx_q) < VTR_PORTS;

  always_comb begin
    for (int p = 0; p < VTR_PORTS; p++) begin
      pvid_d[p] = pvid_q[p];
      ppri_d[p] = ppri_q[p];
    end
    // out-of-range port index writes are ignored
    if (done && !rd_q && sel_q && port_ok) begin
      pvid_d[idx_q[1:0]] = wdat_q[VTR_VID_LSB +: VTR_VID_W];
      ppri_d[idx_q[1:0]] = wdat_q[VTR_PRI_LSB +: VTR_PRI_W];
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < VTR_PORTS; p++) begin
      if (sys_rst) begin
        pvid_q[p] <= VTR_PVID_RESET; // see R4
        ppri_q[p] <= VTR_PPRI_RESET; // see R4
      end else begin
        pvid_q[p] <= pvid_d[p];
        ppri_q[p] <= ppri_d[p];
      end
    end
  end

  // ==========================================================
  // vlan table
  // ==========================================================
  logic [VTR_ENTRY_W-1:0] vlan_rd_entry;
  logic [VTR_ENTRY_W-1:0] hit_entry;
  logic hit;
  logic [VTR_VID_W-1:0] eff_vid;
  logic [VTR_PRI_W-1:0] eff_pri;
  logic use_default;
  logic [1:0] src;

  vtr_vlan_store #(
    .ENTRIES(ENTRIES),
    .IDX_W(IDX_W)
  ) u_store (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(done && !rd_q && !sel_q),
    .wr_index(idx_q),
    .wr_entry(wdat_q),
    .rd_index(idx_q),
    .rd_entry(vlan_rd_entry),
    .search_vid(eff_vid),
    .search_hit(hit),
    .search_entry(hit_entry)
  );

  // ==========================================================
  // read result register
  // ==========================================================
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (done && rd_q) begin // see R12
      rdata_d = '0; // see R1
      if (sel_q) begin
        if (port_ok) begin
          rdata_d[VTR_VID_LSB +: VTR_VID_W] = pvid_q[idx_q[1:0]]; // see R2
          rdata_d[VTR_PRI_LSB +: VTR_PRI_W] = ppri_q[idx_q[1:0]]; // see R2
        end
      end else begin
        // layout 17..12 and vid sit as stored, see R8 and R9
        rdata_d[VTR_ENTRY_W-1:0] = vlan_rd_entry;
      end
    end
  end

  // ==========================================================
  // register read port
  // ==========================================================
  logic [31:0] bus_q, bus_d;

  always_comb begin
    bus_d = bus_q;
    if (reg_rd_en) begin
      if (reg_rd_addr == VTR_READ_DATA_OFFSET) begin
        bus_d = rdata_q; // see R1
      end else if (reg_rd_addr == VTR_CMD_STATUS_OFFSET) begin
        bus_d = {31'h0000_0000, vlan_command_status};
      end else begin
        bus_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= VTR_READ_DATA_RESET; // see R4
      bus_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
      bus_q <= bus_d;
    end
  end

  assign reg_rd_data = bus_q;

  // ==========================================================
  // ingress classification
  // ==========================================================
  logic cv_q, cv_d, ca_q, ca_d;
  logic [VTR_VID_W-1:0] cvid_q, cvid_d;
  logic [VTR_PRI_W-1:0] cpri_q, cpri_d;
  logic [VTR_PORTS-1:0] cfwd_q, cfwd_d, cut_q, cut_d;
  logic src_ok;

  // port 3 does not exist; clamp to keep array reads in range
  assign src_ok = frm_port < 2'(VTR_PORTS);
  assign src = src_ok ? frm_port : 2'h0;
  assign use_default = !frm_tagged || frm_vid == VTR_NULL_VID; // see R3
  assign eff_vid = use_default ? pvid_q[src] : frm_vid; // see R3
  assign eff_pri = use_default ? ppri_q[src] : frm_pri; // see R3

  always_comb begin
    cv_d = frm_valid;
    cvid_d = eff_vid;
    cpri_d = eff_pri;
    ca_d = 1'b0;
    cfwd_d = '0;
    cut_d = '0;
    if (frm_valid && src_ok && hit) begin
      ca_d = vtr_member(hit_entry, int'(src))
          || admit_nonmember_config[src]; // see R5 R6
      for (int e = 0; e < VTR_PORTS; e++) begin
        cfwd_d[e] = vtr_member(hit_entry, e); // see R5 R6
        cut_d[e] = vtr_member(hit_entry, e) && egress_port_type_config[e]
            && vtr_untag(hit_entry, int'(src)); // see R7
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cv_q <= 1'b0;
      ca_q <= 1'b0;
      cvid_q <= '0;
      cpri_q <= '0;
      cfwd_q <= '0;
      cut_q <= '0;
    end else begin
      cv_q <= cv_d;
      ca_q <= ca_d;
      cvid_q <= cvid_d;
      cpri_q <= cpri_d;
      cfwd_q <= cfwd_d;
      cut_q <= cut_d;
    end
  end

  assign cls_valid = cv_q;
  assign cls_accept = ca_q;
  assign cls_vid = cvid_q;
  assign cls_pri = cpri_q;
  assign cls_fwd_mask = cfwd_q;
  assign cls_untag_mask = cut_q;
endmodule : vtr_read_data
`default_nettype wire

// *** test/vtr_read_data_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module vtr_read_data_properties
  import vtr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_rd_addr,
  input wire logic [31:0] reg_rd_data,
  input wire logic cmd_start,
  input wire logic vlan_command_status,
  input wire logic frm_valid,
  input wire logic [1:0] frm_port,
  input wire logic cls_valid,
  input wire logic cls_accept,
  input wire logic [VTR_PORTS-1:0] cls_fwd_mask,
  input wire logic [VTR_PORTS-1:0] cls_untag_mask
);
  // ==========================================================
  // register port
  // ==========================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic mapped;
  assign mapped = (reg_rd_addr == VTR_READ_DATA_OFFSET) ||
                  (reg_rd_addr == VTR_CMD_STATUS_OFFSET);
  a_rsv_zero: assert property (reg_rd_data[31:18] == 14'h0000)
    else $error("reserved read bits not zero");
  a_unmapped_zero: assert property (reg_rd_en && !mapped |=>
    reg_rd_data == 32'h0000_0000) else $error("unmapped read not zero");
  a_status_read: assert property (reg_rd_en &&
    reg_rd_addr == VTR_CMD_STATUS_OFFSET |=>
    reg_rd_data == {31'h0000_0000, $past(vlan_command_status)})
    else $error("status read wrong");
  a_data_hold: assert property (!reg_rd_en |=> $stable(reg_rd_data))
    else $error("read data changed without a read");
  // reset itself is the antecedent, so no disable here
  a_reset_clear: assert property (disable iff (1'b0) sys_rst |=>
    reg_rd_data == 32'h0000_0000 && !vlan_command_status && !cls_valid)
    else $error("outputs not cleared by reset");
  // ==========================================================
  // command and classification
  // ==========================================================
  a_pend_start: assert property (cmd_start && !vlan_command_status |=>
    vlan_command_status) else $error("pending bit did not rise");
  a_pend_len: assert property ($rose(vlan_command_status) |->
    ##1 vlan_command_status ##1 !vlan_command_status)
    else $error("pending bit length wrong");
  a_pend_cause: assert property ($rose(vlan_command_status) |->
    $past(cmd_start)) else $error("pending bit rose unasked");
  a_untag_member: assert property (
    (cls_untag_mask & ~cls_fwd_mask) == 3'h0)
    else $error("untag on a non-member port");
  a_bad_port: assert property (frm_valid && frm_port == 2'h3 |=>
    !cls_accept && cls_fwd_mask == 3'h0) else $error("invalid port accepted");
  a_cls_follow: assert property (frm_valid |=> cls_valid)
    else $error("no classification answer");
  c_cmd: cover property (cmd_start && !vlan_command_status);
  c_accept: cover property (cls_valid && cls_accept);
  c_drop: cover property (cls_valid && !cls_accept);
endmodule : vtr_read_data_properties

bind vtr_read_data vtr_read_data_properties u_props (.sys_clk, .sys_rst,
  .reg_rd_en, .reg_rd_addr, .reg_rd_data, .cmd_start, .vlan_command_status,
  .frm_valid, .frm_port, .cls_valid, .cls_accept, .cls_fwd_mask,
  .cls_untag_mask);
`default_nettype wire

// *** test/vtr_read_data_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module vtr_read_data_tb
  import vtr_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_rd_en = 1'b0;
  logic [15:0] reg_rd_addr = 16'h0000;
  logic [31:0] reg_rd_data;
  logic cmd_start = 1'b0;
  logic cmd_read = 1'b0;
  logic table_select_port_default = 1'b0;
  logic [3:0] cmd_index = 4'h0;
  logic [17:0] cmd_wr_data = 18'h0_0000;
  logic vlan_command_status;
  logic [2:0] admit_nonmember_config = 3'h0;
  logic [2:0] egress_port_type_config = 3'h0;
  logic frm_valid = 1'b0;
  logic [1:0] frm_port = 2'h0;
  logic frm_tagged = 1'b0;
  logic [11:0] frm_vid = 12'h000;
  logic [2:0] frm_pri = 3'h0;
  logic cls_valid;
  logic cls_accept;
  logic [11:0] cls_vid;
  logic [2:0] cls_pri;
  logic [2:0] cls_fwd_mask;
  logic [2:0] cls_untag_mask;
  int n_mismatch = 0;
  int n_checks = 0;

  always #4 sys_clk = ~sys_clk;

  vtr_read_data #(.ENTRIES(16)) vtr_read_data_inst (.sys_clk, .sys_rst,
    .reg_rd_en, .reg_rd_addr, .reg_rd_data, .cmd_start, .cmd_read,
    .table_select_port_default, .cmd_index, .cmd_wr_data,
    .vlan_command_status, .admit_nonmember_config, .egress_port_type_config,
    .frm_valid, .frm_port, .frm_tagged, .frm_vid, .frm_pri, .cls_valid,
    .cls_vid, .cls_pri, .cls_accept, .cls_fwd_mask, .cls_untag_mask);

  // ==========================================================
  // access tasks
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd_en <= 1'b1;
    reg_rd_addr <= a;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    check(reg_rd_data, exp);
  endtask : rd

  // returns only once pending has cleared, so callers never overlap
  task automatic cmd(input logic r, input logic pt, input logic [3:0] idx,
                     input logic [17:0] d);
    int n;
    @(posedge sys_clk);
    cmd_start <= 1'b1;
    cmd_read <= r;
    table_select_port_default <= pt;
    cmd_index <= idx;
    cmd_wr_data <= d;
    @(posedge sys_clk);
    cmd_start <= 1'b0;
    n = 0;
    #1;
    while (vlan_command_status === 1'b1 && n < 10) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(n, 32'h0000_0002);
    if (n == 10) begin
      n_mismatch++;
      conclude();
    end
  endtask : cmd

  // exp packs valid, vid, pri, accept, forward mask, untag mask
  task automatic frm(input logic [1:0] p, input logic t, input logic [11:0] v,
                     input logic [2:0] pr, input logic [22:0] exp,
                     input logic [22:0] m = 23'h7F_FFFF);
    @(posedge sys_clk);
    frm_valid <= 1'b1;
    frm_port <= p;
    frm_tagged <= t;
    frm_vid <= v;
    frm_pri <= pr;
    @(posedge sys_clk);
    frm_valid <= 1'b0;
    #1;
    check({cls_valid, cls_vid, cls_pri, cls_accept, cls_fwd_mask,
           cls_untag_mask} & m, exp & m);
  endtask : frm

  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(VTR_READ_DATA_OFFSET, 32'h0000_0000);
    rd(VTR_CMD_STATUS_OFFSET, 32'h0000_0000);
    rd(16'h1234, 32'h0000_0000);
    cmd(1'b1, 1'b1, 4'h1, 18'h0_0000);
    rd(VTR_READ_DATA_OFFSET, 32'h0000_0000);
    $display("test reset done");
    cmd(1'b0, 1'b0, 4'h0, 18'h3_A005);
    rd(VTR_READ_DATA_OFFSET, 32'h0000_0000);
    cmd(1'b0, 1'b0, 4'h1, 18'h0_3007);
    cmd(1'b1, 1'b0, 4'h0, 18'h0_0000);
    rd(VTR_READ_DATA_OFFSET, 32'h0003_A005);
    cmd(1'b1, 1'b0, 4'h1, 18'h0_0000);
    rd(VTR_READ_DATA_OFFSET, 32'h0000_3007);
    $display("test vlan table done");
    // stray bits 17 and 15 must not survive in the port layout
    cmd(1'b0, 1'b1, 4'h1, 18'h2_B005);
    cmd(1'b1, 1'b1, 4'h1, 18'h0_0000);
    rd(VTR_READ_DATA_OFFSET, 32'h0000_3005);
    cmd(1'b1, 1'b1, 4'h3, 18'h0_0000);
    rd(VTR_READ_DATA_OFFSET, 32'h0000_0000);
    // index 5 aliases port 1 in its low bits; the write must be ignored
    cmd(1'b0, 1'b1, 4'h5, 18'h0_7ABC);
    $display("test port table done");
    // status read while busy; a start held high while busy is dropped
    @(posedge sys_clk);
    cmd_start <= 1'b1;
    cmd_read <= 1'b1;
    table_select_port_default <= 1'b1;
    cmd_index <= 4'h1;
    @(posedge sys_clk);
    cmd_read <= 1'b0;
    reg_rd_en <= 1'b1;
    reg_rd_addr <= VTR_CMD_STATUS_OFFSET;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    check(reg_rd_data, 32'h0000_0001);
    @(posedge sys_clk);
    cmd_start <= 1'b0;
    rd(VTR_READ_DATA_OFFSET, 32'h0000_3005);
    $display("test busy status done");
    @(posedge sys_clk);
    egress_port_type_config <= 3'h7;
    frm(2'h1, 1'b0, 12'h000, 3'h0, {1'b1, 12'h005, 3'h3, 1'b1, 3'h7, 3'h0});
    frm(2'h1, 1'b1, 12'h000, 3'h2, {1'b1, 12'h005, 3'h3, 1'b1, 3'h7, 3'h0});
    frm(2'h2, 1'b1, 12'h005, 3'h6, {1'b1, 12'h005, 3'h6, 1'b1, 3'h7, 3'h7});
    frm(2'h1, 1'b1, 12'h007, 3'h2, {1'b1, 12'h007, 3'h2, 1'b0, 3'h1, 3'h0});
    frm(2'h0, 1'b1, 12'h007, 3'h2, {1'b1, 12'h007, 3'h2, 1'b1, 3'h1, 3'h1});
    @(posedge sys_clk);
    admit_nonmember_config <= 3'h2;
    egress_port_type_config <= 3'h6;
    frm(2'h1, 1'b1, 12'h007, 3'h2, {1'b1, 12'h007, 3'h2, 1'b1, 3'h1, 3'h0});
    frm(2'h0, 1'b1, 12'h007, 3'h2, {1'b1, 12'h007, 3'h2, 1'b1, 3'h1, 3'h0});
    frm(2'h3, 1'b1, 12'h005, 3'h1, 23'h40_0000, 23'h40_007F);
    frm(2'h2, 1'b1, 12'h009, 3'h1, 23'h40_0000, 23'h40_007F);
    $display("test frames done");
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(VTR_READ_DATA_OFFSET, 32'h0000_0000);
    cmd(1'b1, 1'b1, 4'h1, 18'h0_0000);
    rd(VTR_READ_DATA_OFFSET, 32'h0000_0000);
    cmd(1'b1, 1'b0, 4'h0, 18'h0_0000);
    rd(VTR_READ_DATA_OFFSET, 32'h0000_0000);
    frm(2'h1, 1'b0, 12'h000, 3'h0, 23'h40_0000);
    $display("test second reset done");
    conclude();
  end
endmodule : vtr_read_data_tb
`default_nettype wire
